// File: design/reset_source_ctrl.sv
// Reset source qualification, threshold guard and reset-cause flags.
// Assumes APB master on clk_sys; comparator and watchdog inputs async.
//
// Overview of operation
// - Qualified supply-low resets outside power-down, sets cause flag
// - Short supply-low glitches ignored entirely
// - Four legal threshold codes, same trip level
// - Illegal threshold code resets after delay, flags
// - Illegal code reset restores threshold power-on value
// - Supply-low reset delayed; threshold kept
// - Supply-low reset disabled during power-down
// - Low-voltage flag: hardware sets, software clears
// - Corrupt-select flag: hardware sets, software clears
// - Run watchdog timeout: full reset plus timeout flag
// - Sleep timeout: clear PC and SP only
// - Settle 15-16 fast, 1-2 slow cycles
// - Timeout and power-down flag table per reset
// - Power-on gives full core initialisation
// - Halt timeout keeps registers; run timeout doesn't
// - Power-down flag: halt sets, clear-watchdog clears
// - Watchdog-code corruption flag set, software clears
`timescale 1ns/1ps
`include "reset_ctrl_params.svh"
module reset_source_ctrl (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_low_in,
  input wire logic wdog_timeout_in,
  input wire logic [4:0] watchdog_enable_code,
  input wire logic halt_exec,
  input wire logic clr_wdog_exec,
  input wire logic fast_clk_sel,
  output logic full_reset,
  output logic pc_sp_reset,
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tick_if tk ();
  reset_ctrl_pkg::seq_state_t state_reg;
  reset_ctrl_pkg::rst_src_t src_reg;
  logic [1:0] low_sync_reg, to_sync_reg;
  logic to_prev_reg;
  logic [7:0] threshold_code_reg;
  logic lowv_reset_cause_flag_reg, select_corrupt_flag_reg;
  logic wdog_ctrl_corrupt_flag_reg, idle_sysclk_keep_reg;
  logic timeout_status_flag_reg, powerdown_status_flag_reg;
  logic halted_reg;
  logic [3:0] qual_reg;
  logic lowv_qualified;
  logic [1:0] delay_reg;
  logic [4:0] cnt_reg;
  logic [2:0] irq_stat_reg, irq_mask_reg;
  logic wr_en, rd_en, to_rise, thresh_bad, wcode_bad;
  logic [31:0] rdata_next;

  function automatic logic thresh_legal(input logic [7:0] c);
    thresh_legal = (c == `THRESH_OK1) || (c == `THRESH_OK2) ||
                   (c == `THRESH_OK3) || (c == `THRESH_OK4);
  endfunction

  slow_tick_gen u_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      low_sync_reg <= 2'h0;
      to_sync_reg <= 2'h0;
      to_prev_reg <= 1'b0;
    end
    else
    begin
      low_sync_reg <= {low_sync_reg[0], supply_low_in};
      to_sync_reg <= {to_sync_reg[0], wdog_timeout_in};
      to_prev_reg <= to_sync_reg[1];
    end
  end
  assign to_rise = to_sync_reg[1] && !to_prev_reg;
  assign thresh_bad = !thresh_legal(threshold_code_reg);
  assign wcode_bad = (watchdog_enable_code != `WDOG_OK1) &&
                     (watchdog_enable_code != `WDOG_OK2);

  // ----------------------------------------------------------------
  // Supply-low qualification on slow ticks
  // ----------------------------------------------------------------
  // Low must persist past QUAL_TICKS slow ticks; shorter is dropped.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      qual_reg <= 4'h0;
    else if (!low_sync_reg[1] || halted_reg)
      qual_reg <= 4'h0;
    else if (tk.tick && qual_reg != `QUAL_TICKS)
      qual_reg <= qual_reg + 4'h1;
  end
  assign lowv_qualified = (qual_reg == `QUAL_TICKS);

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg <= reset_ctrl_pkg::ST_RUN;
      src_reg <= reset_ctrl_pkg::SRC_LOWV;
      delay_reg <= 2'h0;
      cnt_reg <= 5'h00;
    end
    else
    begin
      unique case (state_reg)
        reset_ctrl_pkg::ST_RUN:
        begin
          delay_reg <= 2'h0;
          if (lowv_qualified)
          begin
            src_reg <= reset_ctrl_pkg::SRC_LOWV;
            state_reg <= reset_ctrl_pkg::ST_DELAY;
          end
          else if (thresh_bad)
          begin
            src_reg <= reset_ctrl_pkg::SRC_THRESH;
            state_reg <= reset_ctrl_pkg::ST_DELAY;
          end
          else if (wcode_bad)
          begin
            src_reg <= reset_ctrl_pkg::SRC_WDOG_CODE;
            state_reg <= reset_ctrl_pkg::ST_DELAY;
          end
          else if (to_rise && halted_reg)
          begin
            src_reg <= reset_ctrl_pkg::SRC_WDOG_TO;
            cnt_reg <= `RST_PULSE;
            state_reg <= reset_ctrl_pkg::ST_PARTIAL;
          end
          else if (to_rise)
          begin
            src_reg <= reset_ctrl_pkg::SRC_WDOG_TO;
            cnt_reg <= `RST_PULSE;
            state_reg <= reset_ctrl_pkg::ST_FULL;
          end
        end
        reset_ctrl_pkg::ST_DELAY:
          // Two or three slow ticks depending on phase at detection
          if (tk.tick)
          begin
            if (delay_reg == `RST_DELAY_TICKS)
            begin
              cnt_reg <= `RST_PULSE;
              state_reg <= reset_ctrl_pkg::ST_FULL;
            end
            else
              delay_reg <= delay_reg + 2'h1;
          end
        reset_ctrl_pkg::ST_FULL, reset_ctrl_pkg::ST_PARTIAL:
          if (cnt_reg == 5'h01)
          begin
            cnt_reg <= fast_clk_sel ? `SETTLE_FAST : `SETTLE_SLOW;
            state_reg <= reset_ctrl_pkg::ST_SETTLE;
          end
          else
            cnt_reg <= cnt_reg - 5'h01;
        reset_ctrl_pkg::ST_SETTLE:
          if (cnt_reg == 5'h01)
            state_reg <= reset_ctrl_pkg::ST_RUN;
          else
            cnt_reg <= cnt_reg - 5'h01;
        default:
          state_reg <= reset_ctrl_pkg::ST_RUN;
      endcase
    end
  end

  // Power-on reset_n gives the full core initialisation too
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      full_reset <= 1'b1;
      pc_sp_reset <= 1'b1;
    end
    else
    begin
      full_reset <= (state_reg == reset_ctrl_pkg::ST_FULL);
      pc_sp_reset <= (state_reg == reset_ctrl_pkg::ST_FULL) ||
                     (state_reg == reset_ctrl_pkg::ST_PARTIAL);
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // Threshold select register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      threshold_code_reg <= `THRESH_POR;
    else if (state_reg == reset_ctrl_pkg::ST_FULL &&
             src_reg == reset_ctrl_pkg::SRC_THRESH)
      threshold_code_reg <= `THRESH_POR;
    else if (wr_en && paddr == `OFS_THRESH)
      threshold_code_reg <= pwdata[7:0];
  end

  // ----------------------------------------------------------------
  // Reset-cause flags; never touched by the resets they record
  // ----------------------------------------------------------------
  // Hardware set wins over a same-cycle software clear.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      lowv_reset_cause_flag_reg <= 1'b0;
      select_corrupt_flag_reg <= 1'b0;
      wdog_ctrl_corrupt_flag_reg <= 1'b0;
      idle_sysclk_keep_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == `OFS_CAUSE)
      begin
        idle_sysclk_keep_reg <= pwdata[`BIT_KEEP];
        if (!pwdata[`BIT_LOWV])
          lowv_reset_cause_flag_reg <= 1'b0;
        if (!pwdata[`BIT_LCORR])
          select_corrupt_flag_reg <= 1'b0;
        if (!pwdata[`BIT_WCORR])
          wdog_ctrl_corrupt_flag_reg <= 1'b0;
      end
      if (lowv_qualified && state_reg == reset_ctrl_pkg::ST_RUN)
        lowv_reset_cause_flag_reg <= 1'b1;
      if (thresh_bad)
        select_corrupt_flag_reg <= 1'b1;
      if (wcode_bad)
        wdog_ctrl_corrupt_flag_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Timeout and power-down status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      timeout_status_flag_reg <= 1'b0;
      powerdown_status_flag_reg <= 1'b0;
      halted_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == reset_ctrl_pkg::ST_RUN && to_rise)
      begin
        timeout_status_flag_reg <= 1'b1;
        halted_reg <= 1'b0;
      end
      else if (clr_wdog_exec)
      begin
        timeout_status_flag_reg <= 1'b0;
        powerdown_status_flag_reg <= 1'b0;
      end
      else if (halt_exec)
      begin
        timeout_status_flag_reg <= 1'b0;
        powerdown_status_flag_reg <= 1'b1;
        halted_reg <= 1'b1;
      end
      else if (state_reg == reset_ctrl_pkg::ST_FULL)
        halted_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg &
        ~((wr_en && paddr == `OFS_IRQ_STAT) ? pwdata[2:0] : 3'h0)) |
        {lowv_qualified, thresh_bad, wcode_bad};
      if (wr_en && paddr == `OFS_IRQ_MASK)
        irq_mask_reg <= pwdata[2:0];
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // APB read path; unmapped addresses return zero with pslverr
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      `OFS_THRESH: rdata_next = {24'h000000, threshold_code_reg};
      `OFS_CAUSE: rdata_next = {24'h000000, idle_sysclk_keep_reg, 4'h0,
        lowv_reset_cause_flag_reg, select_corrupt_flag_reg,
        wdog_ctrl_corrupt_flag_reg};
      `OFS_STATUS: rdata_next = {29'h00000000, halted_reg,
        powerdown_status_flag_reg, timeout_status_flag_reg};
      `OFS_IRQ_STAT: rdata_next = {29'h00000000, irq_stat_reg};
      `OFS_IRQ_MASK: rdata_next = {29'h00000000, irq_mask_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `OFS_THRESH ||
        paddr == `OFS_CAUSE || paddr == `OFS_STATUS ||
        paddr == `OFS_IRQ_STAT || paddr == `OFS_IRQ_MASK);
      if (rd_en)
        prdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_short_low_ignored;
    @(posedge clk_sys) disable iff (!reset_n)
    !low_sync_reg[1] |=> qual_reg == 4'h0;
  endproperty
  a_short_low_ignored: assert property (p_short_low_ignored)
    else $error("qualifier not cleared");

  property p_lowv_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    (lowv_qualified && state_reg == reset_ctrl_pkg::ST_RUN)
      |=> lowv_reset_cause_flag_reg;
  endproperty
  a_lowv_flag: assert property (p_lowv_flag)
    else $error("low voltage flag not set");

  property p_sel_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    thresh_bad |=> select_corrupt_flag_reg;
  endproperty
  a_sel_flag: assert property (p_sel_flag)
    else $error("select corrupt flag not set");

  property p_restore;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_reg == reset_ctrl_pkg::ST_FULL &&
     src_reg == reset_ctrl_pkg::SRC_THRESH)
      |=> threshold_code_reg == `THRESH_POR;
  endproperty
  a_restore: assert property (p_restore)
    else $error("threshold not restored");

  property p_keep;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_reg == reset_ctrl_pkg::ST_FULL &&
     src_reg == reset_ctrl_pkg::SRC_LOWV && !wr_en)
      |=> $stable(threshold_code_reg);
  endproperty
  a_keep: assert property (p_keep)
    else $error("threshold changed on low voltage reset");

  property p_pd_off;
    @(posedge clk_sys) disable iff (!reset_n)
    halted_reg |=> qual_reg == 4'h0;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("qualifier active in power down");

  property p_partial;
    @(posedge clk_sys) disable iff (!reset_n)
    state_reg == reset_ctrl_pkg::ST_PARTIAL |=> pc_sp_reset && !full_reset;
  endproperty
  a_partial: assert property (p_partial)
    else $error("halt timeout gave full reset");

  property p_halt_pdf;
    @(posedge clk_sys) disable iff (!reset_n)
    (halt_exec && !clr_wdog_exec && !(state_reg == reset_ctrl_pkg::ST_RUN
     && to_rise)) |=> powerdown_status_flag_reg;
  endproperty
  a_halt_pdf: assert property (p_halt_pdf)
    else $error("power down flag not set by halt");

  property p_to_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_reg == reset_ctrl_pkg::ST_RUN && to_rise)
      |=> timeout_status_flag_reg;
  endproperty
  a_to_flag: assert property (p_to_flag)
    else $error("timeout flag not set");

  property p_settle_fast;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_reg != reset_ctrl_pkg::ST_SETTLE ##1
     (state_reg == reset_ctrl_pkg::ST_SETTLE && fast_clk_sel))
      |-> ##15 (state_reg == reset_ctrl_pkg::ST_SETTLE)
      ##1 (state_reg == reset_ctrl_pkg::ST_RUN);
  endproperty
  a_settle_fast: assert property (p_settle_fast)
    else $error("fast settle length wrong");

  property p_settle_slow;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_reg != reset_ctrl_pkg::ST_SETTLE ##1
     (state_reg == reset_ctrl_pkg::ST_SETTLE && !fast_clk_sel))
      |-> ##1 (state_reg == reset_ctrl_pkg::ST_SETTLE)
      ##1 (state_reg == reset_ctrl_pkg::ST_RUN);
  endproperty
  a_settle_slow: assert property (p_settle_slow)
    else $error("slow settle length wrong");

  c_lowv: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_reg == reset_ctrl_pkg::ST_DELAY ##1 lowv_reset_cause_flag_reg);
  c_partial: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_reg == reset_ctrl_pkg::ST_PARTIAL);
  c_thresh: cover property (@(posedge clk_sys) disable iff (!reset_n)
    thresh_bad ##1 select_corrupt_flag_reg);
endmodule

// File: design/reset_ctrl_params.svh
// Constants for the reset source and flag controller.
// Assumes a 100 MHz system clock and an APB register slave.
`ifndef RESET_CTRL_PARAMS_SVH
`define RESET_CTRL_PARAMS_SVH
`define OFS_THRESH 12'h000
`define OFS_CAUSE 12'h004
`define OFS_STATUS 12'h008
`define OFS_IRQ_STAT 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_CMD 12'h014
`define THRESH_POR 8'h55
`define THRESH_OK1 8'h55
`define THRESH_OK2 8'h33
`define THRESH_OK3 8'h99
`define THRESH_OK4 8'hAA
`define WDOG_OK1 5'h0A
`define WDOG_OK2 5'h15
`define BIT_WCORR 0
`define BIT_LCORR 1
`define BIT_LOWV 2
`define BIT_KEEP 7
`define BIT_TO 0
`define BIT_PDF 1
`define BIT_HALT 2
`define SLOW_DIV 12'hC35
`define QUAL_TICKS 4'h4
`define RST_DELAY_TICKS 2'h2
`define SETTLE_FAST 5'h10
`define SETTLE_SLOW 5'h02
`define RST_PULSE 5'h04
`endif

// File: design/reset_ctrl_pkg.sv
// Types shared by the reset controller files.
// Assumes reset_ctrl_params.svh supplies the numeric constants.
package reset_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_DELAY, ST_FULL, ST_PARTIAL, ST_SETTLE
  } seq_state_t;
  typedef enum logic [1:0] {
    SRC_LOWV, SRC_THRESH, SRC_WDOG_CODE, SRC_WDOG_TO
  } rst_src_t;
endpackage

// File: design/tick_if.sv
// Interface carrying the slow-oscillator tick between design modules.
// Assumes one clock domain.
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// File: design/slow_tick_gen.sv
// Divider giving the slow-oscillator rate as a one-cycle enable.
// Assumes clk_sys at 100 MHz.
`timescale 1ns/1ps
`include "reset_ctrl_params.svh"
module slow_tick_gen (
  input wire logic clk_sys,
  input wire logic reset_n,
  tick_if.src tk
);
  logic [11:0] cnt_reg;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cnt_reg <= 12'h000;
      tk.tick <= 1'b0;
    end
    else if (cnt_reg == `SLOW_DIV - 12'h001)
    begin
      cnt_reg <= 12'h000;
      tk.tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 12'h001;
      tk.tick <= 1'b0;
    end
  end
endmodule

// File: test/core_model.sv
// Model of the supply comparator, watchdog counter and CPU core strobes.
// Assumes callers enter its tasks just after a rising edge of clk_sys.
`timescale 1ns/1ps
`include "reset_ctrl_params.svh"
module core_model (
  input wire logic clk_sys,
  output logic supply_low_in,
  output logic wdog_timeout_in,
  output logic [4:0] watchdog_enable_code,
  output logic halt_exec,
  output logic clr_wdog_exec,
  output logic fast_clk_sel
);
  initial
  begin
    supply_low_in = 1'b0;
    wdog_timeout_in = 1'b0;
    watchdog_enable_code = `WDOG_OK1;
    halt_exec = 1'b0;
    clr_wdog_exec = 1'b0;
    fast_clk_sel = 1'b1;
  end

  // ------------------------------
  // Level controls
  // ------------------------------
  task automatic set_cfg(input logic [4:0] code, input logic fast);
    watchdog_enable_code <= code;
    fast_clk_sel <= fast;
  endtask

  task automatic supply(input logic low);
    supply_low_in <= low;
  endtask

  // Held high until a reset shows, so a slow sync never misses it
  task automatic overflow();
    wdog_timeout_in <= 1'b1;
  endtask

  // Drop every cause once a reset starts, so none re-arms afterwards
  task automatic calm();
    supply_low_in <= 1'b0;
    wdog_timeout_in <= 1'b0;
    watchdog_enable_code <= `WDOG_OK1;
  endtask

  // ------------------------------
  // One-cycle instruction strobes
  // ------------------------------
  task automatic strobe(input logic halt);
    halt_exec <= halt;
    clr_wdog_exec <= ~halt;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    clr_wdog_exec <= 1'b0;
  endtask
endmodule

// File: test/test_reset_source_and_flag_control.sv
// Self-checking bench for the reset source and flag controller.
// Assumes core_model stands for the comparator, watchdog and core.
`timescale 1ns/1ps
`include "reset_ctrl_params.svh"
module test_reset_source_and_flag_control;
  localparam int TICK = int'(`SLOW_DIV);
  localparam logic [31:0] PULSE = {27'h0, `RST_PULSE};
  logic clk_sys, reset_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, hit;
  logic supply_low_in, wdog_timeout_in, halt_exec, clr_wdog_exec;
  logic fast_clk_sel, full_reset, pc_sp_reset, irq;
  logic [4:0] watchdog_enable_code;
  int failures = 0;
  int n_tests = 0;
  int lat, fw, wid;

  always #5 clk_sys = ~clk_sys;

  core_model cpu_u (
    .clk_sys(clk_sys), .supply_low_in(supply_low_in),
    .wdog_timeout_in(wdog_timeout_in),
    .watchdog_enable_code(watchdog_enable_code), .halt_exec(halt_exec),
    .clr_wdog_exec(clr_wdog_exec), .fast_clk_sel(fast_clk_sel)
  );
  reset_source_ctrl dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_low_in(supply_low_in),
    .wdog_timeout_in(wdog_timeout_in),
    .watchdog_enable_code(watchdog_enable_code), .halt_exec(halt_exec),
    .clr_wdog_exec(clr_wdog_exec), .fast_clk_sel(fast_clk_sel),
    .full_reset(full_reset), .pc_sp_reset(pc_sp_reset), .irq(irq)
  );

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic test_done();
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      test_done();
    end
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      if (pc_sp_reset !== 1'b0)
        hit = 1'b1;
    end
  endtask

  // Latency to the reset, then widths of both reset outputs
  task automatic wait_pulse(input int bound);
    lat = 0;
    fw = 0;
    wid = 0;
    while (pc_sp_reset !== 1'b1 && lat < bound)
    begin
      @(posedge clk_sys);
      lat++;
    end
    if (pc_sp_reset !== 1'b1)
    begin
      failures++;
      test_done();
    end
    cpu_u.calm();
    while (pc_sp_reset === 1'b1 && wid < 100)
    begin
      wid++;
      fw += int'(full_reset === 1'b1);
      @(posedge clk_sys);
    end
    repeat (40) @(posedge clk_sys);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_por();
    rc(`OFS_THRESH, 32'h00000055);
    rc(`OFS_CAUSE, 32'h00000000);
    apb(1'b1, `OFS_CAUSE, 32'h00000087);
    rc(`OFS_CAUSE, 32'h00000080);
    apb(1'b1, `OFS_CAUSE, 32'h00000000);
    apb(1'b1, `OFS_STATUS, 32'h000000FF);
    rc(`OFS_STATUS, 32'h00000000);
    apb(1'b0, 12'h020, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    check(rd, 32'h00000000);
  endtask

  task automatic t_legal();
    logic [7:0] codes [4];
    codes = '{`THRESH_OK1, `THRESH_OK4, `THRESH_OK3, `THRESH_OK2};
    foreach (codes[i])
    begin
      apb(1'b1, `OFS_THRESH, {24'h0, codes[i]});
      rc(`OFS_THRESH, {24'h0, codes[i]});
    end
    // Short dip well inside the qualification time
    hit = 1'b0;
    cpu_u.supply(1'b1);
    quiet(2 * TICK);
    cpu_u.supply(1'b0);
    quiet(4 * TICK);
    check({31'h0, hit}, 32'h00000000);
    rc(`OFS_CAUSE, 32'h00000000);
  endtask

  task automatic t_lowv();
    cpu_u.supply(1'b1);
    wait_pulse(9 * TICK);
    check(32'(fw), PULSE);
    rc(`OFS_THRESH, 32'h00000033);
    rc(`OFS_CAUSE, 32'h00000004);
    rc(`OFS_STATUS, 32'h00000000);
    rc(`OFS_IRQ_STAT, 32'h00000004);
    // Masked: the level stays low until the mask opens
    check({31'h0, irq}, 32'h00000000);
    apb(1'b1, `OFS_IRQ_MASK, 32'h00000004);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h00000001);
    apb(1'b1, `OFS_IRQ_STAT, 32'h00000004);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h00000000);
    apb(1'b1, `OFS_IRQ_MASK, 32'h00000000);
    apb(1'b1, `OFS_CAUSE, 32'h00000000);
    rc(`OFS_CAUSE, 32'h00000000);
  endtask

  task automatic t_illegal();
    apb(1'b1, `OFS_THRESH, 32'h00000012);
    wait_pulse(4 * TICK);
    check({31'h0, lat > 2 * TICK - 10 && lat < 3 * TICK + 30}, 32'h1);
    check(32'(fw), PULSE);
    rc(`OFS_THRESH, 32'h00000055);
    rc(`OFS_CAUSE, 32'h00000002);
  endtask

  task automatic t_wcode();
    cpu_u.set_cfg(5'h03, 1'b1);
    wait_pulse(4 * TICK);
    check({31'h0, lat > 2 * TICK - 10 && lat < 3 * TICK + 30}, 32'h1);
    rc(`OFS_CAUSE, 32'h00000003);
    apb(1'b1, `OFS_CAUSE, 32'h00000000);
    rc(`OFS_CAUSE, 32'h00000000);
  endtask

  task automatic t_run_to();
    cpu_u.overflow();
    wait_pulse(100);
    check(32'(fw), PULSE);
    rc(`OFS_STATUS, 32'h00000001);
    rc(`OFS_CAUSE, 32'h00000000);
  endtask

  task automatic t_halt();
    cpu_u.set_cfg(`WDOG_OK2, 1'b0);
    cpu_u.strobe(1'b1);
    rc(`OFS_STATUS, 32'h00000006);
    hit = 1'b0;
    cpu_u.supply(1'b1);
    quiet(6 * TICK);
    cpu_u.supply(1'b0);
    check({31'h0, hit}, 32'h00000000);
    rc(`OFS_CAUSE, 32'h00000000);
    cpu_u.overflow();
    wait_pulse(100);
    check(32'(fw), 32'h00000000);
    check(32'(wid), PULSE);
    apb(1'b0, `OFS_STATUS, 32'h00000000);
    check(rd & 32'h00000003, 32'h00000003);
    cpu_u.strobe(1'b0);
    apb(1'b0, `OFS_STATUS, 32'h00000000);
    check(rd & 32'h00000002, 32'h00000000);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    reset_n <= 1'b0;
    paddr <= 12'h000;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h00000000;
    repeat (4) @(posedge clk_sys);
    check({31'h0, full_reset}, 32'h00000001);
    check({31'h0, pc_sp_reset}, 32'h00000001);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_por();
    t_legal();
    t_lowv();
    t_illegal();
    t_wcode();
    t_run_to();
    t_halt();
    test_done();
  end
endmodule
